/* shared/chan_if.sv */
// Signals between the register block and one channel cell.
`timescale 1ns/1ps
interface chan_if;
    single_action_submodule_pkg::mode_t mode;
    logic edge_out;
    logic wr_ctrl;
    logic wr_flag_bit;
    logic wr_force;
    logic wr_data;
    logic [15:0] wdata;
    logic rd_flag_one;
    logic [15:0] timebase;
    logic tick;
    logic capture;
    logic flag;
    logic pin_out;
    logic [15:0] data;

    modport regs (
        output mode, edge_out, wr_ctrl, wr_flag_bit, wr_force, wr_data,
        output wdata, rd_flag_one, timebase, tick, capture,
        input flag, pin_out, data
    );
    modport chan (
        input mode, edge_out, wr_ctrl, wr_flag_bit, wr_force, wr_data,
        input wdata, rd_flag_one, timebase, tick, capture,
        output flag, pin_out, data
    );
endinterface

/* shared/single_action_submodule_defines.svh */
// Register offsets, field positions and reset values of the channel pair.
`ifndef SINGLE_ACTION_SUBMODULE_DEFINES_SVH
`define SINGLE_ACTION_SUBMODULE_DEFINES_SVH

// ============================================================
// Register indices; the byte address is four times the index.
`define SINGLE_ACTION_SUBMODULE_IDX_CTRL_A 2'h0
`define SINGLE_ACTION_SUBMODULE_IDX_DATA_A 2'h1
`define SINGLE_ACTION_SUBMODULE_IDX_CTRL_B 2'h2
`define SINGLE_ACTION_SUBMODULE_IDX_DATA_B 2'h3
`define SINGLE_ACTION_SUBMODULE_ADDR_BITS 8

// ============================================================
// Field positions of the status/interrupt/control word.
`define SINGLE_ACTION_SUBMODULE_BIT_FLAG 15
`define SINGLE_ACTION_SUBMODULE_BIT_LVL_HI 14
`define SINGLE_ACTION_SUBMODULE_BIT_LVL_LO 12
`define SINGLE_ACTION_SUBMODULE_BIT_ARB 11
`define SINGLE_ACTION_SUBMODULE_BIT_ENABLE 10
`define SINGLE_ACTION_SUBMODULE_BIT_BSL 8
`define SINGLE_ACTION_SUBMODULE_BIT_IN 7
`define SINGLE_ACTION_SUBMODULE_BIT_FORCE 5
`define SINGLE_ACTION_SUBMODULE_BIT_EDOUT 4
`define SINGLE_ACTION_SUBMODULE_BIT_MODE_HI 1
`define SINGLE_ACTION_SUBMODULE_BIT_MODE_LO 0

// ============================================================
// Reset values.
`define SINGLE_ACTION_SUBMODULE_RST_LEVEL 3'h0
`define SINGLE_ACTION_SUBMODULE_RST_DATA 16'h0000
`define SINGLE_ACTION_SUBMODULE_RST_PRDATA 32'h0000_0000

`endif

/* shared/single_action_submodule_pkg.sv */
// Types shared by the channel pair and its channel cells.
package single_action_submodule_pkg;

    // ========================================================
    // Channel operating modes.
    typedef enum logic [1:0] {
        input_capture_mode = 2'b00,
        output_port_mode = 2'b01,
        output_compare_mode = 2'b10,
        output_compare_toggle_mode = 2'b11
    } mode_t;

    // ========================================================
    // State of one channel cell.
    typedef struct packed {
        logic flag;
        logic armed;
        logic pin_out;
        logic [15:0] data;
    } chan_state_t;

    // ========================================================
    // State of the register block and interrupt output.
    typedef struct packed {
        logic [2:0] interrupt_level;
        logic arb;
        logic [1:0] interrupt_enable_bit;
        logic [1:0] bus_select;
        logic [1:0] edge_out;
        mode_t [1:0] mode;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq_req;
        logic [2:0] irq_level;
        logic irq_channel_b;
    } top_state_t;

endpackage

/* sim/single_action_submodule_checker.sv */
// Port assertions for the channel pair.
`timescale 1ns/1ps
`include "single_action_submodule_defines.svh"
module single_action_submodule_checker (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB side.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SINGLE_ACTION_SUBMODULE_ADDR_BITS-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt side.
    input wire logic irq_req,
    input wire logic [2:0] irq_level,
    input wire logic irq_channel_b
);
    // ============================================================
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // An access phase still waiting for its answer.
    sequence wait_acc;
        psel && penable && !pready;
    endsequence
    sequence bad_acc;
        wait_acc ##0 (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0);
    endsequence
    a_ready_follows: assert property (wait_acc |=> pready)
        else $error("no answer after access");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (bad_acc |=> pslverr)
        else $error("unmapped access not refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_read_upper: assert property (pready && !pwrite |-> !prdata[31:16])
        else $error("upper read half not zero");
    a_irq_level: assert property (irq_req |-> irq_level != 3'h0)
        else $error("request with zero level");
    a_idle_level: assert property (!irq_req |-> irq_level == 3'h0)
        else $error("level without request");
    a_b_needs_req: assert property (irq_channel_b |-> irq_req)
        else $error("channel B shown without request");
endmodule
bind single_action_submodule_pair single_action_submodule_checker single_action_submodule_checker_i (.ref_clk(ref_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq_level(irq_level),
    .irq_channel_b(irq_channel_b));

/* sim/single_action_submodule_event_flag_irq_bench.sv */
// Self-checking bench for the channel pair.
`timescale 1ns/1ps
module single_action_submodule_event_flag_irq_bench;
    typedef struct {logic [7:0] a; logic [15:0] w; logic [31:0] r;
        logic e;} row_t;
    logic ref_clk = 1'b0, arst_n = 1'b0, pwrite, psel, penable;
    logic pready, pslverr, time_tick = 1'b0, irq_req, irq_channel_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] timebase = 16'h0000;
    logic [1:0] capture_strobe = 2'h0, pin_in = 2'h0, pin_out;
    logic [2:0] irq_level;
    logic [31:0] irqv;
    int n_errors = 0, n_tests = 0, cyc = 0;
    row_t rows[5] = '{'{8'h00, 16'h7400, 32'h7400, 1'b0},
        '{8'h04, 16'h1234, 32'h1234, 1'b0},
        '{8'h08, 16'h7403, 32'h0403, 1'b0},
        '{8'h0C, 16'h0055, 32'h0055, 1'b0},
        '{8'h10, 16'hFFFF, 32'h0000, 1'b1}};
    assign irqv = {27'h0, irq_channel_b, irq_req, irq_level};
    // ============================================================
    // Clock, parts and watchdog
    always #10 ref_clk = ~ref_clk;
    single_action_submodule_host single_action_submodule_host_i (.ref_clk(ref_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    single_action_submodule_pair single_action_submodule_pair_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timebase(timebase), .time_tick(time_tick),
        .capture_strobe(capture_strobe), .pin_in(pin_in),
        .pin_out(pin_out), .irq_req(irq_req), .irq_level(irq_level),
        .irq_channel_b(irq_channel_b));
    // A hung handshake ends the run as a failure.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            give_verdict();
        end
    end
    // ============================================================
    // Tasks
    task automatic give_verdict();
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", n, x, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        logic [31:0] r;
        logic e;
        single_action_submodule_host_i.xfer(a, 1'b1, d, r, e);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] x, logic xe = 1'b0);
        logic [31:0] r;
        logic e;
        single_action_submodule_host_i.xfer(a, 1'b0, 16'h0000, r, e);
        chk("prdata", x, r);
        chk("pslverr", {31'h0, xe}, {31'h0, e});
    endtask
    // One event cycle, then time for flag and request to settle.
    task automatic ev(logic [15:0] t, logic [1:0] c, logic k);
        @(posedge ref_clk);
        timebase <= t;
        capture_strobe <= c;
        time_tick <= k;
        @(posedge ref_clk);
        capture_strobe <= 2'h0;
        time_tick <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(8'h00, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r, rows[i].e);
        end
        // The input level shows the pin only in capture mode.
        pin_in <= 2'h3;
        rd(8'h00, 32'h7480);
        rd(8'h08, 32'h0403);
        pin_in <= 2'h0;
        ev(16'h0ABC, 2'h1, 1'b0);
        chk("irq", 32'h0F, irqv);
        ev(16'h0BCD, 2'h1, 1'b0);
        rd(8'h00, 32'hF400);
        rd(8'h04, 32'h0BCD);
        wr(8'h00, 16'hF400);
        rd(8'h00, 32'hF400);
        ev(16'h0CDE, 2'h1, 1'b0);
        wr(8'h00, 16'h7400);
        rd(8'h00, 32'hF400);
        wr(8'h00, 16'hF400);
        wr(8'h00, 16'h7400);
        rd(8'h00, 32'hF400);
        wr(8'h00, 16'h7400);
        rd(8'h00, 32'h7400);
        chk("irq", 32'h00, irqv);
        wr(8'h04, 16'h0055);
        wr(8'h00, 16'h7412);
        ev(16'h0055, 2'h0, 1'b1);
        chk("pin_out", 32'h3, {30'h0, pin_out});
        chk("irq", 32'h0F, irqv);
        ev(16'h0055, 2'h0, 1'b1);
        chk("pin_out", 32'h1, {30'h0, pin_out});
        rd(8'h08, 32'h8403);
        rd(8'h00, 32'hF492);
        wr(8'h00, 16'h7412);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h1F, irqv);
        // Channel B in output port mode, force on A, compares while set.
        wr(8'h08, 16'h0411);
        rd(8'h08, 32'h0491);
        wr(8'h00, 16'h7402);
        wr(8'h00, 16'h7422);
        rd(8'h00, 32'h7402);
        chk("pin_out", 32'h2, {30'h0, pin_out});
        chk("irq", 32'h00, irqv);
        wr(8'h00, 16'h7412);
        ev(16'h0055, 2'h0, 1'b1);
        chk("pin_out", 32'h3, {30'h0, pin_out});
        chk("irq", 32'h0F, irqv);
        wr(8'h00, 16'hF402);
        ev(16'h0055, 2'h0, 1'b1);
        chk("pin_out", 32'h2, {30'h0, pin_out});
        rd(8'h00, 32'hF402);
        rd(8'h08, 32'h8491);
        // A reset in mid-run clears flags, requests and outputs.
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        chk("irq", 32'h00, irqv);
        chk("pin_out", 32'h0, {30'h0, pin_out});
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h0);
        give_verdict();
    end
endmodule

/* sim/single_action_submodule_host.sv */
// Host processor model: one APB master with a transfer task.
`timescale 1ns/1ps
module single_action_submodule_host (
    // Clock.
    input wire logic ref_clk,
    // APB master.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ============================================================
    // Transfer
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // read then write
    // Software clears a flag by a read and a later zero write; request
    // is held until pready so no slow answer is ever missed.
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [15:0] d, output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* src/single_action_submodule_channel.sv */
// One single-action channel: data word, output flop and event flag.
`timescale 1ns/1ps
`include "single_action_submodule_defines.svh"
module single_action_submodule_channel (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register block side.
    chan_if.chan bus
);

    single_action_submodule_pkg::chan_state_t s;
    single_action_submodule_pkg::chan_state_t next_s;
    logic cap;
    logic match;
    logic evt;

    // ========================================================
    // Events and actions.
    // An event always clears the arming, so a clear that was armed
    // before the event can never remove the new event's flag.
    always_comb begin
        next_s = s;
        cap = bus.capture && (bus.mode == single_action_submodule_pkg::input_capture_mode);
        match = bus.tick && (bus.timebase == s.data) &&
            (bus.mode != single_action_submodule_pkg::input_capture_mode);
        evt = cap || match;
        if (cap) begin
            next_s.data = bus.timebase;
        end else if (bus.wr_data) begin
            next_s.data = bus.wdata;
        end
        unique case (bus.mode)
            single_action_submodule_pkg::output_compare_mode: begin
                if (match || bus.wr_force) begin
                    next_s.pin_out = bus.edge_out;
                end
            end
            single_action_submodule_pkg::output_compare_toggle_mode: begin
                if (match || bus.wr_force) begin
                    next_s.pin_out = !s.pin_out;
                end
            end
            single_action_submodule_pkg::output_port_mode: begin
                next_s.pin_out = bus.edge_out;
            end
            single_action_submodule_pkg::input_capture_mode: begin
                next_s.pin_out = s.pin_out;
            end
        endcase
        if (bus.rd_flag_one) begin
            next_s.armed = 1'b1;
        end
        if (bus.wr_ctrl) begin
            next_s.armed = 1'b0;
        end
        if (bus.wr_ctrl && !bus.wr_flag_bit && s.armed && !evt) begin
            next_s.flag = 1'b0;
        end
        if (evt) begin
            next_s.flag = 1'b1;
            next_s.armed = 1'b0;
        end
    end

    // ========================================================
    // State register; system reset clears the flag.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{flag: 1'b0, armed: 1'b0, pin_out: 1'b0,
                data: `SINGLE_ACTION_SUBMODULE_RST_DATA};
        end else begin
            s <= next_s;
        end
    end

    assign bus.flag = s.flag;
    assign bus.pin_out = s.pin_out;
    assign bus.data = s.data;

endmodule

/* src/single_action_submodule_pair.sv */
// Two-channel single-action submodule with APB registers and interrupt.
//
// Summary of operation
// - Hardware sets the flag on any capture or compare event; reset clears.
// - Interrupt requested when flag, enable bit and non-zero level coincide.
// - Capture while flag set still latches the new time, flag stays.
// - Compare while flag set still acts normally, flag stays.
// - Toggle match while flag set still toggles the output, flag stays.
// - Output port internal match while flag set works, flag stays.
// - Besides reset, flag clears only by reading it as one, then writing zero.
// - An event between that read and write cancels the clear.
// - Three level bits are plain read/write at any time.
// - Channel A wins over B; both share one level and arbitration bit.
//
// Register map; each 16-bit register sits in the low half of one
// aligned 32-bit word.
//   0x00 control word of channel A, also holding the shared level
//        and arbitration bits.
//   0x04 data word of channel A.
//   0x08 control word of channel B.
//   0x0C data word of channel B.
// Any other address is answered with an error and reads as zero, and a
// write to it is dropped.
//
// Control word fields.
//   15     event flag, set by hardware, cleared by read then zero write.
//   14:12  interrupt level, shared, in the channel A word only.
//   11     arbitration bit, shared, storage only.
//   10     interrupt enable of this channel.
//   8      bus select, storage only.
//   7      input level, read only.
//   5      force strobe, always reads as zero.
//   4      edge or output bit.
//   1:0    mode: 00 capture, 01 output port, 10 compare, 11 toggle.
//
// Every access takes exactly one wait state. The interrupt outputs are
// registered, so they follow a flag or enable change one cycle later.
// A user must not rely on the arbitration bit: it is only stored.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "single_action_submodule_defines.svh"
module single_action_submodule_pair (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SINGLE_ACTION_SUBMODULE_ADDR_BITS-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time base and channel events.
    input wire logic [15:0] timebase,
    input wire logic time_tick,
    input wire logic [1:0] capture_strobe,
    input wire logic [1:0] pin_in,
    // Channel outputs.
    output logic [1:0] pin_out,
    // Interrupt request.
    output logic irq_req,
    output logic [2:0] irq_level,
    output logic irq_channel_b
);

    single_action_submodule_pkg::top_state_t s;
    single_action_submodule_pkg::top_state_t next_s;
    chan_if ch [2] ();
    logic [1:0] flag;
    logic [1:0] pin_q;
    logic [15:0] data [2];
    logic [1:0] req;
    logic access;
    logic done;
    logic mapped;
    logic [1:0] idx;
    logic [15:0] rword;

    // ========================================================
    // Bus decode. The answer comes one cycle into the access phase,
    // so the read word is prepared before the completing edge.
    assign access = psel && penable;
    assign done = access && s.pready;
    assign idx = paddr[3:2];
    // Byte lanes are not decoded: only aligned word addresses map.
    assign mapped = (paddr[1:0] == 2'b00) &&
        (paddr[`SINGLE_ACTION_SUBMODULE_ADDR_BITS-1:4] == '0);

    // ========================================================
    // Channel cells, one per generate pass.
    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            assign ch[c].mode = s.mode[c];
            assign ch[c].edge_out = s.edge_out[c];
            // Writes reach a cell only on the completing edge, so the
            // wait state can never apply one write twice.
            assign ch[c].wr_ctrl = done && mapped && pwrite &&
                (idx == 2'(2 * c));
            assign ch[c].wr_flag_bit = pwdata[`SINGLE_ACTION_SUBMODULE_BIT_FLAG];
            assign ch[c].wr_force = ch[c].wr_ctrl &&
                pwdata[`SINGLE_ACTION_SUBMODULE_BIT_FORCE];
            assign ch[c].wr_data = done && mapped && pwrite &&
                (idx == 2'(2 * c + 1));
            assign ch[c].wdata = pwdata[15:0];
            // Arming uses the word really returned, so a flag set during
            // the wait state cannot arm a clear that software never saw.
            // qualifying read seen
            assign ch[c].rd_flag_one = done && mapped && !pwrite &&
                (idx == 2'(2 * c)) && s.prdata[`SINGLE_ACTION_SUBMODULE_BIT_FLAG];
            assign ch[c].timebase = timebase;
            assign ch[c].tick = time_tick;
            assign ch[c].capture = capture_strobe[c];
            assign flag[c] = ch[c].flag;
            assign pin_q[c] = ch[c].pin_out;
            assign data[c] = ch[c].data;
            assign req[c] = ch[c].flag && s.interrupt_enable_bit[c] &&
                (s.interrupt_level != 3'h0);
            single_action_submodule_channel u_chan (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .bus(ch[c])
            );
        end
    endgenerate

    // ========================================================
    // Read word of the addressed register. The input level shows
    // the pin in capture mode and the output flop otherwise.
    always_comb begin
        rword = 16'h0000;
        if (idx[0]) begin
            rword = data[idx[1]];
        end else begin
            rword[`SINGLE_ACTION_SUBMODULE_BIT_FLAG] = flag[idx[1]];
            rword[`SINGLE_ACTION_SUBMODULE_BIT_ENABLE] = s.interrupt_enable_bit[idx[1]];
            rword[`SINGLE_ACTION_SUBMODULE_BIT_BSL] = s.bus_select[idx[1]];
            rword[`SINGLE_ACTION_SUBMODULE_BIT_IN] =
                (s.mode[idx[1]] == single_action_submodule_pkg::input_capture_mode) ?
                pin_in[idx[1]] : pin_q[idx[1]];
            rword[`SINGLE_ACTION_SUBMODULE_BIT_EDOUT] = s.edge_out[idx[1]];
            rword[`SINGLE_ACTION_SUBMODULE_BIT_MODE_HI:`SINGLE_ACTION_SUBMODULE_BIT_MODE_LO] = s.mode[idx[1]];
            // Level and arbitration bits read as zero in the B word.
            // shared level fields
            if (!idx[1]) begin
                rword[`SINGLE_ACTION_SUBMODULE_BIT_LVL_HI:`SINGLE_ACTION_SUBMODULE_BIT_LVL_LO] =
                    s.interrupt_level;
                rword[`SINGLE_ACTION_SUBMODULE_BIT_ARB] = s.arb;
            end
        end
    end

    // ========================================================
    // Next state: bus handshake, control writes and interrupt.
    always_comb begin
        next_s = s;
        // An unmapped access is still answered, with an error, so a
        // stray address can never hang the bus.
        next_s.pready = access && !s.pready;
        next_s.pslverr = access && !s.pready && !mapped;
        if (access && !s.pready) begin
            next_s.prdata = (mapped && !pwrite) ?
                {16'h0000, rword} : `SINGLE_ACTION_SUBMODULE_RST_PRDATA;
        end
        // Control fields follow a completed write of a control word.
        if (done && mapped && pwrite && !idx[0]) begin
            next_s.interrupt_enable_bit[idx[1]] =
                pwdata[`SINGLE_ACTION_SUBMODULE_BIT_ENABLE];
            next_s.bus_select[idx[1]] = pwdata[`SINGLE_ACTION_SUBMODULE_BIT_BSL];
            next_s.edge_out[idx[1]] = pwdata[`SINGLE_ACTION_SUBMODULE_BIT_EDOUT];
            next_s.mode[idx[1]] = single_action_submodule_pkg::mode_t'(
                pwdata[`SINGLE_ACTION_SUBMODULE_BIT_MODE_HI:`SINGLE_ACTION_SUBMODULE_BIT_MODE_LO]);
            if (!idx[1]) begin
                next_s.interrupt_level =
                    pwdata[`SINGLE_ACTION_SUBMODULE_BIT_LVL_HI:`SINGLE_ACTION_SUBMODULE_BIT_LVL_LO];
                next_s.arb = pwdata[`SINGLE_ACTION_SUBMODULE_BIT_ARB];
            end
        end
        // The request is registered: it lags the flag by one cycle, but
        // a level field that changes mid-cycle cannot glitch the pin.
        // drive request
        next_s.irq_req = |req;
        next_s.irq_level = (|req) ? s.interrupt_level : 3'h0;
        next_s.irq_channel_b = !req[0] && req[1];
    end

    // ========================================================
    // State register.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{
                interrupt_level: `SINGLE_ACTION_SUBMODULE_RST_LEVEL,
                arb: 1'b0,
                interrupt_enable_bit: 2'b00,
                bus_select: 2'b00,
                edge_out: 2'b00,
                mode: '{single_action_submodule_pkg::input_capture_mode,
                    single_action_submodule_pkg::input_capture_mode},
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: `SINGLE_ACTION_SUBMODULE_RST_PRDATA,
                irq_req: 1'b0,
                irq_level: 3'h0,
                irq_channel_b: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from flops here or in the channel cells.
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pin_out = pin_q;
    assign irq_req = s.irq_req;
    assign irq_level = s.irq_level;
    assign irq_channel_b = s.irq_channel_b;

endmodule
